/* inc/dwt_pkg.sv */
package dwt_pkg;

  // channel count and converter word width
  localparam int NUM_CH = 2;
  localparam int DATA_W = 12;

  // register byte offsets on the apb window
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SOFTWARE_TRIGGER_BIT = 8'h04;
  localparam logic [7:0] OFF_DUAL_12R = 8'h20;
  localparam logic [7:0] OFF_DUAL_12L = 8'h24;
  localparam logic [7:0] OFF_DUAL_8R = 8'h28;
  localparam logic [7:0] OFF_DOR1 = 8'h2C;
  localparam logic [7:0] OFF_DOR2 = 8'h30;
  localparam logic [7:0] OFF_STATUS = 8'h34;

  // field positions
  localparam int CH_FIELD_W = 16;
  localparam int ST_PEND_BIT = 12;
  localparam int ST_UDR_BIT = 13;
  localparam int D12R_CH2_LSB = 16;
  localparam int D12L_CH1_LSB = 4;
  localparam int D12L_CH2_LSB = 20;
  localparam int D8R_CH2_LSB = 8;

  // reset values and full scale
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [11:0] LFSR_SEED = 12'hAAA;
  localparam logic [11:0] DATA_RST = 12'h000;
  localparam logic [11:0] DATA_MAX = 12'hFFF;

  // timing: hardware trigger to output load, in pclk cycles
  localparam int HW_TRIG_DELAY = 3;

  // encodings
  localparam logic [2:0] TSEL_SOFTWARE = 3'h7;
  localparam logic [1:0] WAVE_OFF = 2'h0;
  localparam logic [1:0] WAVE_NOISE = 2'h1;
  localparam logic [3:0] MAMP_FULL = 4'hB;

  // one channel's half of the control register, high bit first, channel_enable last at bit 0
  typedef struct packed {
    logic [1:0] reserved;
    logic underrun_irq_enable;
    logic dma_request_enable;
    logic [3:0] mask_amplitude_select;
    logic [1:0] wave_select;
    logic [2:0] trigger_source_select;
    logic trigger_enable;
    logic buffer_off;
    logic channel_enable;
  } dwt_chan_cfg_t;

endpackage : dwt_pkg

/* design/dwt_top.sv */
`timescale 1ns/100ps
`default_nettype none

module dwt_top #(
  parameter int NUM_HW_TRIG = 7, // hardware trigger lines, codes 0..6
  parameter int ADDR_W = 8 // apb address width
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NUM_HW_TRIG-1:0] hw_trig,
  output logic [dwt_pkg::NUM_CH-1:0] dma_req,
  input wire logic [dwt_pkg::NUM_CH-1:0] dma_ack,
  output logic [dwt_pkg::NUM_CH-1:0] underrun_irq,
  output logic [dwt_pkg::NUM_CH-1:0] chan_enable,
  output logic [dwt_pkg::NUM_CH-1:0] out_buffer_off,
  output logic [dwt_pkg::NUM_CH-1:0][dwt_pkg::DATA_W-1:0] dac_data
);

  // refuse configurations the decode cannot serve
  generate
    if (NUM_HW_TRIG < 1 || NUM_HW_TRIG > 7) begin : g_bad_trig
      $error("NUM_HW_TRIG must be 1..7");
    end
    if (ADDR_W < 8) begin : g_bad_addr
      $error("ADDR_W must be at least 8");
    end
  endgenerate

  localparam int NCH = dwt_pkg::NUM_CH;
  localparam int DW = dwt_pkg::DATA_W;

  // mask for noise and top of triangle share one decode
  function automatic logic [11:0] mask_of(input logic [3:0] code);
    logic [11:0] m;
    m = 12'h002 << code;
    if (code >= dwt_pkg::MAMP_FULL) begin
      mask_of = dwt_pkg::DATA_MAX;
    end else begin
      mask_of = m - 12'h001;
    end
  endfunction : mask_of

  // sum without wraparound, pinned at full scale
  function automatic logic [11:0] sat_add(input logic [11:0] a,
                                          input logic [11:0] b);
    logic [12:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat_add = s[12] ? dwt_pkg::DATA_MAX : s[11:0];
  endfunction : sat_add

  // next noise value, taps 12/6/4/1, shifting toward bit 0
  function automatic logic [11:0] lfsr_next(input logic [11:0] l);
    logic fb;
    fb = l[0] ^ l[1] ^ l[4] ^ l[6];
    if (l == 12'h000) begin
      lfsr_next = 12'h001;
    end else begin
      lfsr_next = {fb, l[11:1]};
    end
  endfunction : lfsr_next

  // control halves, one per channel
  dwt_pkg::dwt_chan_cfg_t [NCH-1:0] ctrl_reg;
  logic [NCH-1:0] software_trigger_bit_reg; // software trigger bits
  logic [NCH-1:0] udr_reg; // underrun flags
  logic [DW-1:0] dhr_reg [NCH]; // data holding per channel
  logic dhr_wr_reg; // a dual holding write just happened
  logic [NUM_HW_TRIG-1:0] hw_prev_reg; // for rising-edge detect
  logic [31:0] rdata_reg; // read data captured in setup
  logic [NCH-1:0] sw_clr; // channel consumed its software trigger
  logic [NCH-1:0] udr_set; // channel saw an underrun
  logic [NCH-1:0] pend; // per-channel request pending
  logic [DW-1:0] dor [NCH]; // per-channel output words
  logic [NUM_HW_TRIG-1:0] hw_rise; // one-cycle rising edges

  // apb decode
  logic [7:0] addr8;
  logic mapped;
  logic access;
  logic wr_en;
  logic [NCH-1:0] udr_w1c;

  assign addr8 = paddr[7:0];
  assign access = psel & penable;
  assign wr_en = access & pwrite & mapped;
  assign pready = 1'b1; // zero wait states
  assign pslverr = access & ~mapped; // unmapped address answers error
  assign prdata = rdata_reg;
  assign hw_rise = hw_trig & ~hw_prev_reg;

  // word-aligned hits only; upper address bits must be zero
  always_comb begin
    mapped = 1'b0;
    if ((paddr >> 8) == '0) begin
      unique case (addr8)
        dwt_pkg::OFF_CTRL, dwt_pkg::OFF_SOFTWARE_TRIGGER_BIT, dwt_pkg::OFF_DUAL_12R,
        dwt_pkg::OFF_DUAL_12L, dwt_pkg::OFF_DUAL_8R, dwt_pkg::OFF_DOR1,
        dwt_pkg::OFF_DOR2, dwt_pkg::OFF_STATUS: mapped = 1'b1;
        default: mapped = 1'b0;
      endcase
    end
  end

  // w1c strobes for the underrun flags
  always_comb begin
    udr_w1c = '0;
    if (wr_en && addr8 == dwt_pkg::OFF_STATUS) begin
      for (int c = 0; c < NCH; c++) begin
        udr_w1c[c] = pwdata[c * dwt_pkg::CH_FIELD_W + dwt_pkg::ST_UDR_BIT];
      end
    end
  end

  // read data latched in setup phase so it is a flop in access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_reg <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      rdata_reg <= 32'h00000000;
      unique case (addr8)
        dwt_pkg::OFF_CTRL: begin
          rdata_reg <= {ctrl_reg[1], ctrl_reg[0]};
        end
        dwt_pkg::OFF_SOFTWARE_TRIGGER_BIT: begin
          rdata_reg <= {30'h0, software_trigger_bit_reg};
        end
        dwt_pkg::OFF_DUAL_12R: begin
          rdata_reg <= {4'h0, dhr_reg[1], 4'h0, dhr_reg[0]};
        end
        dwt_pkg::OFF_DOR1: begin
          rdata_reg <= {20'h00000, dor[0]};
        end
        dwt_pkg::OFF_DOR2: begin
          rdata_reg <= {20'h00000, dor[1]};
        end
        dwt_pkg::OFF_STATUS: begin
          for (int c = 0; c < NCH; c++) begin
            rdata_reg[c * dwt_pkg::CH_FIELD_W + dwt_pkg::ST_UDR_BIT] <=
              udr_reg[c];
            rdata_reg[c * dwt_pkg::CH_FIELD_W + dwt_pkg::ST_PEND_BIT] <=
              pend[c];
          end
        end
        // other holding views and unmapped read as zero
        default: begin
          rdata_reg <= 32'h00000000;
        end
      endcase
    end
  end

  // control register; some fields frozen while the channel runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= {dwt_pkg::CTRL_RST, dwt_pkg::CTRL_RST};
    end else if (wr_en && addr8 == dwt_pkg::OFF_CTRL) begin
      for (int c = 0; c < NCH; c++) begin
        ctrl_reg[c] <= pwdata[c * 16 +: 16];
        ctrl_reg[c].reserved <= 2'h0;
        if (ctrl_reg[c].channel_enable) begin
          // write-lock avoids a glitch in a running waveform
          ctrl_reg[c].mask_amplitude_select <=
            ctrl_reg[c].mask_amplitude_select;
          ctrl_reg[c].trigger_source_select <=
            ctrl_reg[c].trigger_source_select;
        end
      end
    end
  end

  // software trigger bits: set by write, dropped once consumed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      software_trigger_bit_reg <= '0;
    end else begin
      for (int c = 0; c < NCH; c++) begin
        if (wr_en && addr8 == dwt_pkg::OFF_SOFTWARE_TRIGGER_BIT && pwdata[c]) begin
          software_trigger_bit_reg[c] <= 1'b1; // a new write wins over the clear
        end else if (sw_clr[c]) begin
          software_trigger_bit_reg[c] <= 1'b0;
        end
      end
    end
  end

  // underrun flags: hardware set beats software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      udr_reg <= '0;
    end else begin
      udr_reg <= udr_set | (udr_reg & ~udr_w1c);
    end
  end

  // dual holding registers, one write feeds both channels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dhr_reg[0] <= dwt_pkg::DATA_RST;
      dhr_reg[1] <= dwt_pkg::DATA_RST;
      dhr_wr_reg <= 1'b0;
    end else begin
      dhr_wr_reg <= 1'b0;
      if (wr_en) begin
        unique case (addr8)
          dwt_pkg::OFF_DUAL_12R: begin
            dhr_reg[0] <= pwdata[11:0];
            dhr_reg[1] <= pwdata[dwt_pkg::D12R_CH2_LSB +: 12];
            dhr_wr_reg <= 1'b1;
          end
          dwt_pkg::OFF_DUAL_12L: begin
            dhr_reg[0] <= pwdata[dwt_pkg::D12L_CH1_LSB +: 12];
            dhr_reg[1] <= pwdata[dwt_pkg::D12L_CH2_LSB +: 12];
            dhr_wr_reg <= 1'b1;
          end
          dwt_pkg::OFF_DUAL_8R: begin
            dhr_reg[0] <= {pwdata[7:0], 4'h0};
            dhr_reg[1] <= {pwdata[dwt_pkg::D8R_CH2_LSB +: 8], 4'h0};
            dhr_wr_reg <= 1'b1;
          end
          // other registers leave holding data alone
          default: begin
            dhr_wr_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // previous level of the trigger lines
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_prev_reg <= '0;
    end else begin
      hw_prev_reg <= hw_trig;
    end
  end

  // per-channel datapath: trigger, generators, output, dma
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    dwt_pkg::dwt_chan_cfg_t cfg;
    logic hw_edge; // selected hardware line rose
    logic sw_fire; // software trigger taken this cycle
    logic hw_load; // hardware trigger matured
    logic load; // output register loads this cycle
    logic step; // generator advances this cycle
    logic [1:0] wave; // effective wave mode
    logic [11:0] mask;
    logic [11:0] value;
    logic [dwt_pkg::HW_TRIG_DELAY-1:0] hw_pipe_reg;
    logic [11:0] lfsr_reg;
    logic [11:0] tri_reg;
    logic tri_up_reg;
    logic [11:0] dor_reg;
    logic pend_reg;

    assign cfg = ctrl_reg[g];
    // each channel sees only its own source selection
    assign hw_edge = cfg.trigger_enable
      && cfg.trigger_source_select != dwt_pkg::TSEL_SOFTWARE
      && 32'(cfg.trigger_source_select) < NUM_HW_TRIG
      && hw_rise[cfg.trigger_source_select];
    assign sw_fire = cfg.trigger_enable
      && cfg.trigger_source_select == dwt_pkg::TSEL_SOFTWARE
      && software_trigger_bit_reg[g];
    assign hw_load = hw_pipe_reg[dwt_pkg::HW_TRIG_DELAY-1];
    // triggers off: holding write reaches output next cycle
    assign load = hw_load | sw_fire
      | (~cfg.trigger_enable & dhr_wr_reg);
    // generators only move on triggers, so trigger_enable gates them
    assign step = cfg.trigger_enable & (hw_load | sw_fire);
    assign wave = cfg.trigger_enable ? cfg.wave_select : dwt_pkg::WAVE_OFF;
    assign mask = mask_of(cfg.mask_amplitude_select);
    assign sw_clr[g] = sw_fire;
    assign pend[g] = pend_reg;
    assign dor[g] = dor_reg;

    // value that the next load will store
    always_comb begin
      if (wave[1]) begin
        value = sat_add(dhr_reg[g], tri_reg);
      end else if (wave == dwt_pkg::WAVE_NOISE) begin
        value = sat_add(dhr_reg[g], lfsr_reg & mask);
      end else begin
        value = dhr_reg[g];
      end
    end

    // hardware trigger delay line
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hw_pipe_reg <= '0;
      end else begin
        hw_pipe_reg <= {hw_pipe_reg[dwt_pkg::HW_TRIG_DELAY-2:0],
                        hw_edge};
      end
    end

    // noise register: own per channel, reset when wave is off
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        lfsr_reg <= dwt_pkg::LFSR_SEED;
      end else if (cfg.wave_select == dwt_pkg::WAVE_OFF) begin
        lfsr_reg <= dwt_pkg::LFSR_SEED;
      end else if (lfsr_reg == 12'h000) begin
        lfsr_reg <= lfsr_next(lfsr_reg);
      end else if (step && wave == dwt_pkg::WAVE_NOISE) begin
        lfsr_reg <= lfsr_next(lfsr_reg);
      end
    end

    // triangle counter: used first, stepped in the same load
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        tri_reg <= 12'h000;
        tri_up_reg <= 1'b1;
      end else if (cfg.wave_select == dwt_pkg::WAVE_OFF) begin
        tri_reg <= 12'h000;
        tri_up_reg <= 1'b1;
      end else if (step && wave[1]) begin
        if (tri_up_reg && tri_reg < mask) begin
          tri_reg <= tri_reg + 12'h001;
          tri_up_reg <= (tri_reg + 12'h001) < mask;
        end else if (tri_reg != 12'h000) begin
          tri_reg <= tri_reg - 12'h001;
          tri_up_reg <= (tri_reg == 12'h001);
        end else begin
          tri_reg <= 12'h001;
          tri_up_reg <= 12'h001 < mask;
        end
      end
    end

    // output data register
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        dor_reg <= dwt_pkg::DATA_RST;
      end else if (load) begin
        dor_reg <= value;
      end
    end

    // dma request: not queued, held until acknowledge
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        pend_reg <= 1'b0;
      end else if (!cfg.dma_request_enable) begin
        pend_reg <= 1'b0; // disabling dma drops a stale request
      end else if (hw_edge && !udr_reg[g] && !(pend_reg && !dma_ack[g])) begin
        pend_reg <= 1'b1;
      end else if (dma_ack[g]) begin
        pend_reg <= 1'b0;
      end
    end

    // second trigger with request still open is an underrun
    assign udr_set[g] = cfg.dma_request_enable && hw_edge
      && !udr_reg[g] && pend_reg && !dma_ack[g];
    // flag blocks new requests but output keeps loading
    assign dma_req[g] = pend_reg & ~udr_reg[g];
    assign underrun_irq[g] = udr_reg[g] & cfg.underrun_irq_enable;
    assign chan_enable[g] = cfg.channel_enable;
    assign out_buffer_off[g] = cfg.buffer_off;
    assign dac_data[g] = dor_reg;
  end

endmodule : dwt_top

`default_nettype wire

/* dv/dwt_top_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module dwt_top_asserts #(
  parameter int NUM_HW_TRIG = 7,
  parameter int ADDR_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [NUM_HW_TRIG-1:0] hw_trig,
  input wire logic [dwt_pkg::NUM_CH-1:0] dma_req,
  input wire logic [dwt_pkg::NUM_CH-1:0] dma_ack,
  input wire logic [dwt_pkg::NUM_CH-1:0] underrun_irq,
  input wire logic [dwt_pkg::NUM_CH-1:0][dwt_pkg::DATA_W-1:0] dac_data
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  dwt_pkg::dwt_chan_cfg_t [1:0] cfg_w; // ctrl word being written
  logic [1:0] ten_s; // shadow trigger enables
  logic [1:0] irq_s; // shadow irq enables
  logic [1:0][2:0] tsel_s; // shadow source codes
  logic [NUM_HW_TRIG-1:0] trig_prev; // line levels one edge ago
  logic [1:0] rise; // accepted hardware trigger edge
  logic wr_acc; // write commit cycle
  assign cfg_w = pwdata;
  assign wr_acc = psel && penable && pwrite;
  // edge detect needs the previous level of every line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_prev <= '0;
    end else begin
      trig_prev <= hw_trig;
    end
  end
  // shadow only what the trigger path and interrupt checks need; freeze is not modelled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ten_s <= '0;
      irq_s <= '0;
      tsel_s <= '0;
    end else if (wr_acc && paddr == ADDR_W'(dwt_pkg::OFF_CTRL)) begin
      for (int c = 0; c < 2; c++) begin
        ten_s[c] <= cfg_w[c].trigger_enable;
        irq_s[c] <= cfg_w[c].underrun_irq_enable;
        tsel_s[c] <= cfg_w[c].trigger_source_select;
      end
    end
  end
  // software code has no line, so guard before indexing
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      rise[c] = ten_s[c] && tsel_s[c] != dwt_pkg::TSEL_SOFTWARE
        && hw_trig[tsel_s[c]] && !trig_prev[tsel_s[c]];
    end
  end
  for (genvar c = 0; c < 2; c++) begin : g_ch
    req_cause_a: assert property (
      $rose(dma_req[c]) |-> $past(rise[c]) || $past(wr_acc))
      else $error("dma request without hardware trigger");
    data_cause_a: assert property (
      $changed(dac_data[c]) |-> $past(rise[c], 4) || $past(wr_acc, 2))
      else $error("output changed without cause");
    underrun_drop_a: assert property (
      dma_req[c] && !dma_ack[c] && rise[c]
      |=> !dma_req[c] && underrun_irq[c] == irq_s[c])
      else $error("second trigger did not raise underrun");
    req_held_a: assert property (
      dma_req[c] && !dma_ack[c] && !rise[c] && !wr_acc |=> dma_req[c])
      else $error("request dropped before acknowledge");
    ack_clear_a: assert property (
      dma_ack[c] && !rise[c] && !wr_acc |=> !dma_req[c])
      else $error("acknowledge did not clear request");
    underrun_hold_a: assert property (
      underrun_irq[c] && !wr_acc |=> underrun_irq[c] && !dma_req[c])
      else $error("request issued during underrun");
    irq_gate_a: assert property (
      underrun_irq[c] |-> irq_s[c])
      else $error("interrupt while its enable is clear");
  end
  dual_load_a: assert property (
    wr_acc && paddr == ADDR_W'(dwt_pkg::OFF_DUAL_12R) && ten_s == 2'b00
    |-> ##2 dac_data == {$past(pwdata[27:16], 2), $past(pwdata[11:0], 2)})
    else $error("dual write not loaded one cycle later");
  cover property (rise[0] && dma_req[0] && !dma_ack[0]);
  cover property (dma_ack[1] && dma_req[1]);
  cover property ($changed(dac_data[1]));
endmodule : dwt_top_asserts
bind dwt_top dwt_top_asserts #(.NUM_HW_TRIG(NUM_HW_TRIG), .ADDR_W(ADDR_W))
  i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hw_trig(hw_trig),
  .dma_req(dma_req), .dma_ack(dma_ack), .underrun_irq(underrun_irq),
  .dac_data(dac_data));
`default_nettype wire

/* dv/dwt_dma_model.sv */
`timescale 1ns/100ps
`default_nettype none
module dwt_dma_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [dwt_pkg::NUM_CH-1:0] dma_req,
  input wire logic [7:0] ack_delay, // FF withholds every acknowledge
  output logic [dwt_pkg::NUM_CH-1:0] dma_ack
);
  logic [1:0][7:0] wait_cnt; // cycles each request has waited
  // each channel served on its own, one pulse per request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= '0;
      dma_ack <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (dma_ack[c] || !dma_req[c]) begin
          wait_cnt[c] <= 8'h00;
          dma_ack[c] <= 1'b0;
        end else if (ack_delay != 8'hFF && wait_cnt[c] >= ack_delay) begin
          dma_ack[c] <= 1'b1;
        end else begin
          wait_cnt[c] <= wait_cnt[c] + 8'h01;
        end
      end
    end
  end
endmodule : dwt_dma_model
`default_nettype wire

/* dv/dac_wave_dma_trigger_logic_test.sv */
`timescale 1ns/100ps
`default_nettype none
module dac_wave_dma_trigger_logic_test;
  logic pclk = 1'b0; // bus clock
  logic presetn = 1'b0; // held low at start
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [6:0] hw_trig = 7'h00; // timer trigger lines
  logic [1:0] dma_req;
  logic [1:0] dma_ack;
  logic [1:0] underrun_irq;
  logic [1:0] ch_en; // channel enable copies
  logic [1:0] boff; // output buffer off copies
  logic [1:0][11:0] dac; // converter words
  logic [7:0] ack_dly = 8'h03; // dma reply delay
  logic [31:0] rd; // last read word
  logic er; // last slave error
  logic [11:0] lf; // expected noise register
  int err_count = 0;
  int num_checks = 0;
  always #10 pclk = ~pclk;
  dwt_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .hw_trig(hw_trig),
    .dma_req(dma_req), .dma_ack(dma_ack), .underrun_irq(underrun_irq),
    .chan_enable(ch_en), .out_buffer_off(boff), .dac_data(dac));
  dwt_dma_model i_dma (.pclk(pclk), .presetn(presetn), .dma_req(dma_req),
    .ack_delay(ack_dly), .dma_ack(dma_ack));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // request held until pready is sampled high; only the watchdog ends a wait
  task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rdc(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    check(rd & m, e);
  endtask : rdc
  // software trigger: the load lands on the following edge
  task automatic swt(input logic [1:0] b);
    xfer(1'b1, dwt_pkg::OFF_SOFTWARE_TRIGGER_BIT, {30'h0, b});
    @(posedge pclk);
    #1;
  endtask : swt
  // one rising edge on a line, returns just after its sampling edge
  task automatic pulse(input int i);
    @(posedge pclk);
    hw_trig[i] <= 1'b1;
    @(posedge pclk);
    hw_trig[i] <= 1'b0;
    #1;
  endtask : pulse
  // old value must stand two edges, new one at the third
  task automatic land(input int c, input logic [11:0] o, input logic [11:0] v);
    repeat (2) @(posedge pclk);
    #1;
    check(32'(dac[c]), 32'(o));
    @(posedge pclk);
    #1;
    check(32'(dac[c]), 32'(v));
  endtask : land
  task automatic idle;
    int n;
    n = 0;
    while (dma_req !== 2'b00 && n < 40) begin
      @(posedge pclk);
      n++;
    end
    #1;
    check(32'(dma_req), 32'h0);
  endtask : idle
  function automatic logic [15:0] cw(input logic en, input logic ten,
      input logic [2:0] ts, input logic [1:0] wv, input logic [3:0] mp,
      input logic dm, input logic iq);
    dwt_pkg::dwt_chan_cfg_t f;
    f = '0;
    f.channel_enable = en;
    f.trigger_enable = ten;
    f.trigger_source_select = ts;
    f.wave_select = wv;
    f.mask_amplitude_select = mp;
    f.dma_request_enable = dm;
    f.underrun_irq_enable = iq;
    return f;
  endfunction : cw
  task automatic t_reset;
    rdc(dwt_pkg::OFF_CTRL, 32'hFFFF_FFFF, 32'h0);
    check({4'h0, dac, dma_req, underrun_irq}, 32'h0);
    // enable and buffer-off bits reach their pins after the commit edge
    xfer(1'b1, dwt_pkg::OFF_CTRL, 32'h0002_0001);
    #1;
    check({28'h0, ch_en, boff}, 32'h6);
    xfer(1'b1, dwt_pkg::OFF_CTRL, 32'h0);
    rdc(8'h3C, 32'hFFFF_FFFF, 32'h0);
    check({31'h0, er}, 32'h1);
  endtask : t_reset
  // all three dual layouts, triggers off
  task automatic t_dual;
    logic [7:0] a [3] = '{dwt_pkg::OFF_DUAL_12R, dwt_pkg::OFF_DUAL_12L,
      dwt_pkg::OFF_DUAL_8R};
    logic [31:0] w [3] = '{32'h0ABC_0123, 32'h5670_89A0, 32'h0000_C35A};
    logic [23:0] e [3] = '{24'hABC123, 24'h56789A, 24'hC305A0};
    for (int i = 0; i < 3; i++) begin
      xfer(1'b1, a[i], w[i]);
      @(posedge pclk);
      #1;
      check(32'(dac), 32'(e[i]));
      rdc(dwt_pkg::OFF_DOR2, 32'hFFF, 32'(e[i][23:12]));
    end
  endtask : t_dual
  task automatic t_sw;
    xfer(1'b1, dwt_pkg::OFF_CTRL,
      {16'h0, cw(1'b0, 1'b1, 3'h7, 2'h0, 4'h0, 1'b0, 1'b0)});
    xfer(1'b1, dwt_pkg::OFF_DUAL_12R, 32'h0444_0777);
    @(posedge pclk);
    #1;
    check(32'(dac), 32'h4445A0);
    swt(2'b01);
    check(32'(dac), 32'h444777);
    rdc(dwt_pkg::OFF_SOFTWARE_TRIGGER_BIT, 32'h3, 32'h0);
    check(32'(dma_req), 32'h0);
  endtask : t_sw
  task automatic t_dma;
    ack_dly <= 8'h03;
    xfer(1'b1, dwt_pkg::OFF_CTRL, {cw(1'b0, 1'b1, 3'h1, 2'h0, 4'h0, 1'b1,
      1'b0), cw(1'b0, 1'b1, 3'h0, 2'h0, 4'h0, 1'b1, 1'b1)});
    xfer(1'b1, dwt_pkg::OFF_DUAL_12R, 32'h0222_0111);
    pulse(0);
    check(32'(dma_req), 32'h1);
    land(0, 12'h777, 12'h111);
    check(32'(dac[1]), 32'h444);
    idle();
    pulse(1);
    check(32'(dma_req), 32'h2);
    land(1, 12'h444, 12'h222);
    idle();
    rdc(dwt_pkg::OFF_STATUS, 32'h2000_2000, 32'h0);
  endtask : t_dma
  task automatic t_udr;
    ack_dly <= 8'hFF;
    pulse(0);
    pulse(0);
    check({28'h0, dma_req, underrun_irq}, 32'h1);
    xfer(1'b1, dwt_pkg::OFF_DUAL_12R, 32'h0222_0333);
    pulse(0);
    check(32'(dma_req), 32'h0);
    land(0, 12'h111, 12'h333);
    rdc(dwt_pkg::OFF_STATUS, 32'h2000, 32'h2000);
    xfer(1'b1, dwt_pkg::OFF_STATUS, 32'h2000);
    rdc(dwt_pkg::OFF_STATUS, 32'h2000, 32'h0);
    check(32'(underrun_irq), 32'h0);
    ack_dly <= 8'h01;
    xfer(1'b1, dwt_pkg::OFF_CTRL,
      {16'h0, cw(1'b0, 1'b1, 3'h0, 2'h0, 4'h0, 1'b0, 1'b1)});
    xfer(1'b1, dwt_pkg::OFF_CTRL,
      {16'h0, cw(1'b0, 1'b1, 3'h0, 2'h0, 4'h0, 1'b1, 1'b1)});
    pulse(0);
    check(32'(dma_req), 32'h1);
    idle();
  endtask : t_udr
  task automatic t_noise;
    lf = dwt_pkg::LFSR_SEED;
    xfer(1'b1, dwt_pkg::OFF_CTRL,
      {16'h0, cw(1'b0, 1'b1, 3'h7, 2'h1, 4'hB, 1'b0, 1'b0)});
    xfer(1'b1, dwt_pkg::OFF_DUAL_12R, 32'h0000_0FF0);
    swt(2'b01);
    check(32'(dac[0]), 32'hFFF);
    xfer(1'b1, dwt_pkg::OFF_DUAL_12R, 32'h0);
    for (int i = 0; i < 4; i++) begin
      lf = {lf[0] ^ lf[1] ^ lf[4] ^ lf[6], lf[11:1]};
      swt(2'b01);
      check(32'(dac[0]), 32'(lf));
    end
    xfer(1'b1, dwt_pkg::OFF_CTRL, 32'h0);
    xfer(1'b1, dwt_pkg::OFF_CTRL,
      {16'h0, cw(1'b1, 1'b1, 3'h7, 2'h1, 4'h3, 1'b0, 1'b0)});
    xfer(1'b1, dwt_pkg::OFF_DUAL_12R, 32'h0000_0100);
    swt(2'b01);
    check(32'(dac[0]), 32'h10A);
    xfer(1'b1, dwt_pkg::OFF_CTRL,
      {16'h0, cw(1'b1, 1'b1, 3'h7, 2'h1, 4'hB, 1'b0, 1'b0)});
    rdc(dwt_pkg::OFF_CTRL, 32'hF00, 32'h300);
  endtask : t_noise
  // triangle on the second channel, both upper-bit codes
  task automatic t_tri;
    int c;
    bit up;
    for (int w = 2; w < 4; w++) begin
      c = 0;
      up = 1'b1;
      xfer(1'b1, dwt_pkg::OFF_CTRL, {cw(1'b0, 1'b1, 3'h7, 2'(w), 4'h1,
        1'b0, 1'b0), 16'h0});
      xfer(1'b1, dwt_pkg::OFF_DUAL_12R, 32'h0100_0000);
      for (int i = 0; i < 8; i++) begin
        swt(2'b10);
        check(32'(dac[1]), 32'h100 + 32'(c));
        if (up && c == 3) up = 1'b0;
        else if (!up && c == 0) up = 1'b1;
        c = up ? c + 1 : c - 1;
      end
      xfer(1'b1, dwt_pkg::OFF_CTRL, 32'h0);
    end
  endtask : t_tri
  task automatic give_verdict;
    $display("checks=%0d errors=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_dual();
    t_sw();
    t_dma();
    t_udr();
    t_noise();
    t_tri();
    give_verdict();
  end
  // run needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge pclk);
    err_count++;
    give_verdict();
  end
endmodule : dac_wave_dma_trigger_logic_test
`default_nettype wire
